//--- hdl/setup_slew_watchdog_command_handler.sv
// setup, slew, start-up value and watchdog command handler
// assumes: an upstream parser presents one decoded command as a one-cycle strobe,
// a downstream formatter turns a reply strobe into characters, a nonvolatile
// store takes write requests and presents its contents at power-up
`timescale 1ns/1ps
module setup_slew_watchdog_command_handler #(
	parameter int TICK_COUNT = cmd_handler_pkg::TICK_CYCLES
)(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic cmdValid,
	input wire cmd_handler_pkg::cmd_s cmdIn,
	input wire logic nvLoadValid,
	input wire logic [cmd_handler_pkg::SETUP_W-1:0] nvSetup,
	input wire logic [cmd_handler_pkg::VAL_W-1:0] nvRamp,
	input wire logic [cmd_handler_pkg::VAL_W-1:0] nvStartup,
	input wire logic [cmd_handler_pkg::VAL_W-1:0] nvWatchdog,
	input wire logic outSetError,
	input wire logic outSlewing,
	input wire logic trimRangeError,
	output cmd_handler_pkg::reply_s reply_r,
	output logic replyValid_r,
	output cmd_handler_pkg::nv_e nvWrite_r,
	output logic [cmd_handler_pkg::VAL_W-1:0] nvWriteData_r,
	output logic [cmd_handler_pkg::SETUP_W-1:0] nvWriteSetup_r,
	output logic outSetValid_r,
	output logic [cmd_handler_pkg::VAL_W-1:0] outTarget_r,
	output logic [cmd_handler_pkg::VAL_W-1:0] outRate_r,
	output logic outFreeze_r,
	output logic controllerReset_r,
	output logic [cmd_handler_pkg::SETUP_W-1:0] activeSetup_r,
	output logic trimOutValid_r,
	output logic trimOutHigh_r,
	output logic [cmd_handler_pkg::VAL_W-1:0] trimOutMeasured_r,
	output logic trimReadbackValid_r,
	output logic trimReadbackHigh_r,
	output logic writeEnable_r
);
	//--------------------------------------------------------------
	// shadow copies and decode
	//--------------------------------------------------------------
	logic [cmd_handler_pkg::SETUP_W-1:0] setup_r;
	logic [cmd_handler_pkg::VAL_W-1:0] ramp_r;
	logic [cmd_handler_pkg::VAL_W-1:0] startup_r;
	logic [cmd_handler_pkg::VAL_W-1:0] watchdog_r;
	logic powerUpPending_r;
	logic powerUpCheck_r;
	logic [31:0] tickCnt_r;
	logic [cmd_handler_pkg::VAL_W-1:0] wdCnt_r;
	logic wdFire;
	logic isProtected;
	cmd_handler_pkg::err_e err;
	logic ok;

	// protected commands write nonvolatile memory or restart
	always_comb
	begin
		case (cmdIn.code)
			cmd_handler_pkg::CMD_REMOTE_RESTART,
			cmd_handler_pkg::CMD_SETUP_WRITE,
			cmd_handler_pkg::CMD_STARTUP_VALUE_PROGRAM,
			cmd_handler_pkg::CMD_WATCHDOG_PERIOD_PROGRAM,
			cmd_handler_pkg::CMD_WRITE_RAMP_PERSISTENT:
				isProtected = 1'b1;
			default:
				isProtected = 1'b0; // ramp_rate_volatile unprotected
		endcase
	end

	// error classification, checksum first, then syntax, protection, value
	always_comb
	begin
		err = cmd_handler_pkg::ERR_NONE;
		if (cmdIn.checksumPresent && !cmdIn.checksumOk)
			err = cmd_handler_pkg::ERR_BAD_CHECKSUM;
		else if (!cmdIn.syntaxOk)
			err = cmd_handler_pkg::ERR_SYNTAX;
		else if (cmdIn.code == cmd_handler_pkg::CMD_SETUP_WRITE
			&& cmdIn.hexCount != 4'(cmd_handler_pkg::HEX_DIGITS))
			err = cmd_handler_pkg::ERR_SYNTAX;
		else if (isProtected && !writeEnable_r)
			err = cmd_handler_pkg::ERR_WRITE_PROTECTED;
		else if (cmdIn.code == cmd_handler_pkg::CMD_WATCHDOG_PERIOD_PROGRAM
			&& cmdIn.value < cmd_handler_pkg::WD_MIN_VAL)
			err = cmd_handler_pkg::ERR_VALUE;
		else if ((cmdIn.code == cmd_handler_pkg::CMD_TRIM_OUTPUT_LOW
			|| cmdIn.code == cmd_handler_pkg::CMD_TRIM_OUTPUT_HIGH)
			&& (outSlewing || trimRangeError))
			err = cmd_handler_pkg::ERR_VALUE;
		else if ((cmdIn.code == cmd_handler_pkg::CMD_TRIM_READBACK_LOW
			|| cmdIn.code == cmd_handler_pkg::CMD_TRIM_READBACK_HIGH) && outSlewing)
			err = cmd_handler_pkg::ERR_VALUE;
		ok = (err == cmd_handler_pkg::ERR_NONE);
	end

	//--------------------------------------------------------------
	// write enable
	//--------------------------------------------------------------
	// set by write_enable, cleared by any other success or write-protected error
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			writeEnable_r <= 1'b0;
		else if (cmdValid)
		begin
			if (cmdIn.code == cmd_handler_pkg::CMD_WRITE_ENABLE && ok)
				writeEnable_r <= 1'b1;
			else if (ok)
				writeEnable_r <= 1'b0;
			else if (err == cmd_handler_pkg::ERR_WRITE_PROTECTED)
				writeEnable_r <= 1'b0;
			// other errors keep the enable
		end
	end

	//--------------------------------------------------------------
	// replies
	//--------------------------------------------------------------
	// one reply per command; errors carry no data and abort the command
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			replyValid_r <= 1'b0;
			reply_r <= '0;
		end
		else
		begin
			replyValid_r <= cmdValid;
			if (cmdValid)
			begin
				reply_r.ok <= ok;
				reply_r.err <= err;
				reply_r.code <= cmdIn.code;
				reply_r.hashPrompt <= cmdIn.hashPrompt;
				reply_r.hasValue <= 1'b0;
				reply_r.hasSetup <= 1'b0;
				reply_r.value <= '0;
				reply_r.setup <= setup_r;
				if (ok)
				begin
					case (cmdIn.code)
						cmd_handler_pkg::CMD_READ_SETUP,
						cmd_handler_pkg::CMD_READ_SETUP_ALIAS:
							reply_r.hasSetup <= 1'b1;
						cmd_handler_pkg::CMD_READ_STORED_RAMP:
						begin
							reply_r.hasValue <= 1'b1;
							reply_r.value <= ramp_r;
						end
						cmd_handler_pkg::CMD_READ_STARTUP_VALUE:
						begin
							reply_r.hasValue <= 1'b1;
							reply_r.value <= startup_r;
						end
						cmd_handler_pkg::CMD_READ_WATCHDOG_PERIOD:
						begin
							reply_r.hasValue <= 1'b1;
							reply_r.value <= watchdog_r;
						end
						cmd_handler_pkg::CMD_RAMP_RATE_VOLATILE,
						cmd_handler_pkg::CMD_STARTUP_VALUE_PROGRAM,
						cmd_handler_pkg::CMD_WATCHDOG_PERIOD_PROGRAM,
						cmd_handler_pkg::CMD_WRITE_RAMP_PERSISTENT,
						cmd_handler_pkg::CMD_TRIM_OUTPUT_LOW,
						cmd_handler_pkg::CMD_TRIM_OUTPUT_HIGH: // echoed argument
						begin
							reply_r.hasValue <= 1'b1;
							reply_r.value <= cmdIn.value;
						end
						cmd_handler_pkg::CMD_SETUP_WRITE:
						begin
							reply_r.hasSetup <= 1'b1;
							reply_r.setup <= cmdIn.setup;
						end
						default:
							reply_r.hasValue <= 1'b0;
					endcase
				end
			end
		end
	end

	//--------------------------------------------------------------
	// nonvolatile writes and shadows
	//--------------------------------------------------------------
	// stored copies follow the store at power-up and each successful write
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			nvWrite_r <= cmd_handler_pkg::NV_NONE;
			nvWriteData_r <= '0;
			nvWriteSetup_r <= '0;
			setup_r <= '0;
			ramp_r <= '0;
			startup_r <= '0;
			watchdog_r <= cmd_handler_pkg::WD_DISABLE_VAL;
		end
		else
		begin
			nvWrite_r <= cmd_handler_pkg::NV_NONE;
			if (nvLoadValid)
			begin
				setup_r <= nvSetup;
				ramp_r <= nvRamp;
				startup_r <= nvStartup;
				watchdog_r <= nvWatchdog;
			end
			else if (cmdValid && ok)
			begin
				case (cmdIn.code)
					cmd_handler_pkg::CMD_SETUP_WRITE:
					begin
						nvWrite_r <= cmd_handler_pkg::NV_SETUP;
						nvWriteSetup_r <= cmdIn.setup;
						setup_r <= cmdIn.setup;
					end
					cmd_handler_pkg::CMD_WRITE_RAMP_PERSISTENT:
					begin
						nvWrite_r <= cmd_handler_pkg::NV_RAMP;
						nvWriteData_r <= cmdIn.value;
						ramp_r <= cmdIn.value;
					end
					cmd_handler_pkg::CMD_STARTUP_VALUE_PROGRAM:
					begin
						nvWrite_r <= cmd_handler_pkg::NV_STARTUP;
						nvWriteData_r <= cmdIn.value;
						startup_r <= cmdIn.value;
					end
					cmd_handler_pkg::CMD_WATCHDOG_PERIOD_PROGRAM:
					begin
						nvWrite_r <= cmd_handler_pkg::NV_WATCHDOG;
						nvWriteData_r <= cmdIn.value;
						watchdog_r <= cmdIn.value;
					end
					default:
						nvWrite_r <= cmd_handler_pkg::NV_NONE;
				endcase
			end
		end
	end

	//--------------------------------------------------------------
	// restart, active setup, power-up output
	//--------------------------------------------------------------
	// active setup (baud etc.) latched only at load and restart
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			activeSetup_r <= '0;
			controllerReset_r <= 1'b0;
			outFreeze_r <= 1'b0;
		end
		else
		begin
			controllerReset_r <= 1'b0;
			if (nvLoadValid)
				activeSetup_r <= nvSetup;
			if (cmdValid && ok && cmdIn.code == cmd_handler_pkg::CMD_REMOTE_RESTART)
			begin
				controllerReset_r <= 1'b1;
				outFreeze_r <= 1'b1;
				activeSetup_r <= setup_r;
			end
			else if (outSetValid_r)
				outFreeze_r <= 1'b0;
		end
	end

	// power-up, watchdog and host slew commands drive the output request
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			powerUpPending_r <= 1'b1;
			powerUpCheck_r <= 1'b0;
			outSetValid_r <= 1'b0;
			outTarget_r <= cmd_handler_pkg::NEG_FULL_SCALE;
			outRate_r <= '0;
		end
		else
		begin
			outSetValid_r <= 1'b0;
			powerUpCheck_r <= 1'b0;
			if (cmdValid && ok && (cmdIn.code == cmd_handler_pkg::CMD_RAMP_RATE_VOLATILE
				|| cmdIn.code == cmd_handler_pkg::CMD_WRITE_RAMP_PERSISTENT))
				outRate_r <= cmdIn.value;
			if (nvLoadValid && powerUpPending_r)
			begin
				powerUpPending_r <= 1'b0;
				powerUpCheck_r <= 1'b1;
				outSetValid_r <= 1'b1;
				outTarget_r <= nvStartup;
				outRate_r <= nvRamp;
			end
			else if (powerUpCheck_r && outSetError)
			begin
				outSetValid_r <= 1'b1;
				outTarget_r <= cmd_handler_pkg::NEG_FULL_SCALE;
			end
			else if (wdFire)
			begin
				outSetValid_r <= 1'b1;
				outTarget_r <= startup_r;
			end
		end
	end

	//--------------------------------------------------------------
	// watchdog
	//--------------------------------------------------------------
	// counts hundredths of a minute since the last successful command
	assign wdFire = (watchdog_r != cmd_handler_pkg::WD_DISABLE_VAL)
		&& (wdCnt_r + 1'b1 >= watchdog_r) && (tickCnt_r == 32'(TICK_COUNT - 1))
		&& !(cmdValid && ok); // a successful command in the firing cycle restarts the period

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b || (cmdValid && ok) || powerUpPending_r)
		begin
			tickCnt_r <= '0;
			wdCnt_r <= '0;
		end
		else if (tickCnt_r == 32'(TICK_COUNT - 1))
		begin
			tickCnt_r <= '0;
			if (wdFire)
				wdCnt_r <= '0;
			else
				wdCnt_r <= wdCnt_r + 1'b1;
		end
		else
			tickCnt_r <= tickCnt_r + 1'b1;
	end

	//--------------------------------------------------------------
	// trims
	//--------------------------------------------------------------
	// pass trim requests to the calibration engine
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			trimOutValid_r <= 1'b0;
			trimOutHigh_r <= 1'b0;
			trimOutMeasured_r <= '0;
			trimReadbackValid_r <= 1'b0;
			trimReadbackHigh_r <= 1'b0;
		end
		else
		begin
			trimOutValid_r <= cmdValid && ok && (cmdIn.code == cmd_handler_pkg::CMD_TRIM_OUTPUT_LOW
				|| cmdIn.code == cmd_handler_pkg::CMD_TRIM_OUTPUT_HIGH);
			trimReadbackValid_r <= cmdValid && ok
				&& (cmdIn.code == cmd_handler_pkg::CMD_TRIM_READBACK_LOW
				|| cmdIn.code == cmd_handler_pkg::CMD_TRIM_READBACK_HIGH);
			if (cmdValid)
			begin
				trimOutHigh_r <= (cmdIn.code == cmd_handler_pkg::CMD_TRIM_OUTPUT_HIGH);
				trimReadbackHigh_r <= (cmdIn.code == cmd_handler_pkg::CMD_TRIM_READBACK_HIGH);
				trimOutMeasured_r <= cmdIn.value;
			end
		end
	end
endmodule

//--- hdl/cmd_handler_pkg.sv
// package: codes, field layouts, timing for the setup/slew/watchdog command handler
// assumes: one 50 MHz clock, character stream already parsed by an upstream framer
package cmd_handler_pkg;
	// command codes delivered by the upstream parser
	typedef enum logic [4:0] {
		CMD_NONE, CMD_READ_SETUP, CMD_READ_SETUP_ALIAS, CMD_READ_STORED_RAMP,
		CMD_READ_STARTUP_VALUE, CMD_READ_WATCHDOG_PERIOD, CMD_REMOTE_RESTART,
		CMD_SETUP_WRITE, CMD_RAMP_RATE_VOLATILE, CMD_STARTUP_VALUE_PROGRAM,
		CMD_TRIM_OUTPUT_LOW, CMD_TRIM_OUTPUT_HIGH, CMD_TRIM_READBACK_LOW,
		CMD_TRIM_READBACK_HIGH, CMD_WATCHDOG_PERIOD_PROGRAM,
		CMD_WRITE_RAMP_PERSISTENT, CMD_WRITE_ENABLE, CMD_OTHER_VALID
	} cmd_e;
	// error classes reported in replies
	typedef enum logic [3:0] {
		ERR_NONE, ERR_BAD_CHECKSUM, ERR_SYNTAX, ERR_VALUE, ERR_WRITE_PROTECTED,
		ERR_LIMIT, ERR_MANUAL_MODE
	} err_e;
	// value fields are BCD-free fixed point: hundredths, signed
	localparam int VAL_W = 32;
	localparam int SETUP_W = 32;
	localparam int HEX_DIGITS = 8;
	// one parsed command
	typedef struct packed {
		cmd_e code;
		logic hashPrompt;
		logic checksumPresent;
		logic checksumOk;
		logic syntaxOk;
		logic [VAL_W-1:0] value;
		logic [SETUP_W-1:0] setup;
		logic [3:0] hexCount;
	} cmd_s;
	// one reply to the reply formatter
	typedef struct packed {
		logic ok;
		err_e err;
		cmd_e code;
		logic hashPrompt;
		logic hasValue;
		logic hasSetup;
		logic [VAL_W-1:0] value;
		logic [SETUP_W-1:0] setup;
	} reply_s;
	// nonvolatile store write request
	typedef enum logic [2:0] {
		NV_NONE, NV_SETUP, NV_RAMP, NV_STARTUP, NV_WATCHDOG
	} nv_e;
	// watchdog: minutes in hundredths
	localparam logic [VAL_W-1:0] WD_DISABLE_VAL = 32'h0098_967F; // 9999999 = 99999.99
	localparam logic [VAL_W-1:0] WD_MIN_VAL = 32'h0000_0010;     // 16 = 0.16
	localparam logic [VAL_W-1:0] NEG_FULL_SCALE = 32'h8000_0000;
	localparam int CLK_HZ = 50_000_000;
	localparam int HUNDREDTH_MIN_MS = 600; // a hundredth of a minute in ms
	localparam int TICK_CYCLES = CLK_HZ / 1000 * HUNDREDTH_MIN_MS;
endpackage

//--- testbench/cmd_handler_properties.sv
// checker: reply timing and write-enable gating of the command handler
// assumes: bound to the handler top; one clock; sync active-low reset
`timescale 1ns/1ps
module cmd_handler_properties (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic cmdValid,
	input wire cmd_handler_pkg::cmd_s cmdIn,
	input wire logic replyValid_r,
	input wire cmd_handler_pkg::reply_s reply_r,
	input wire cmd_handler_pkg::nv_e nvWrite_r,
	input wire logic [cmd_handler_pkg::VAL_W-1:0] outRate_r,
	input wire logic outFreeze_r,
	input wire logic controllerReset_r,
	input wire logic writeEnable_r
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// a command that parses and carries no checksum
	logic clean;
	assign clean = cmdValid && cmdIn.syntaxOk && !cmdIn.checksumPresent;
	chk_reply_echo:
	assert property (cmdValid |=> replyValid_r && reply_r.code == $past(cmdIn.code)
		&& reply_r.hashPrompt == $past(cmdIn.hashPrompt)) else $error("reply late or wrong");
	chk_reply_cause:
	assert property (replyValid_r |-> $past(cmdValid)) else $error("reply without command");
	chk_enable_set:
	assert property (clean && cmdIn.code == cmd_handler_pkg::CMD_WRITE_ENABLE
		|=> writeEnable_r && reply_r.ok) else $error("write enable not set");
	chk_store_clears:
	assert property (nvWrite_r != cmd_handler_pkg::NV_NONE |-> !writeEnable_r && reply_r.ok)
		else $error("enable kept after store");
	chk_protect_refuse:
	assert property (clean && !writeEnable_r
		&& cmdIn.code == cmd_handler_pkg::CMD_STARTUP_VALUE_PROGRAM
		|=> reply_r.err == cmd_handler_pkg::ERR_WRITE_PROTECTED
		&& nvWrite_r == cmd_handler_pkg::NV_NONE) else $error("protected write taken");
	chk_restart_acts:
	assert property (clean && writeEnable_r && cmdIn.code == cmd_handler_pkg::CMD_REMOTE_RESTART
		|=> controllerReset_r && outFreeze_r) else $error("restart not performed");
	chk_restart_gate:
	assert property (controllerReset_r |-> $past(writeEnable_r))
		else $error("restart without enable");
	chk_bad_sum:
	assert property (cmdValid && cmdIn.checksumPresent && !cmdIn.checksumOk
		|=> reply_r.err == cmd_handler_pkg::ERR_BAD_CHECKSUM
		&& nvWrite_r == cmd_handler_pkg::NV_NONE) else $error("bad checksum missed");
	chk_slew_volatile:
	assert property (clean && cmdIn.code == cmd_handler_pkg::CMD_RAMP_RATE_VOLATILE
		|=> outRate_r == $past(cmdIn.value) && nvWrite_r == cmd_handler_pkg::NV_NONE)
		else $error("volatile slew wrong");
	chk_wd_floor:
	assert property (clean && writeEnable_r
		&& cmdIn.code == cmd_handler_pkg::CMD_WATCHDOG_PERIOD_PROGRAM
		&& cmdIn.value < cmd_handler_pkg::WD_MIN_VAL
		|=> reply_r.err == cmd_handler_pkg::ERR_VALUE && writeEnable_r)
		else $error("short watchdog accepted");
endmodule
bind setup_slew_watchdog_command_handler cmd_handler_properties cmd_handler_properties_inst (
	.ref_clk(ref_clk), .rst_b(rst_b), .cmdValid(cmdValid), .cmdIn(cmdIn),
	.replyValid_r(replyValid_r), .reply_r(reply_r), .nvWrite_r(nvWrite_r),
	.outRate_r(outRate_r), .outFreeze_r(outFreeze_r),
	.controllerReset_r(controllerReset_r), .writeEnable_r(writeEnable_r)
);

//--- testbench/nv_store_model.sv
// partner model: nonvolatile store beside the handler
// assumes: one-cycle write pulses; the bench asks for the power-up load
`timescale 1ns/1ps
module nv_store_model #(
	parameter logic [31:0] SETUP0 = '0,
	parameter logic [31:0] RAMP0 = '0,
	parameter logic [31:0] START0 = '0,
	parameter logic [31:0] WD0 = '0
)(
	input wire logic ref_clk,
	input wire logic loadReq,
	input wire cmd_handler_pkg::nv_e nvWrite,
	input wire logic [31:0] wrData,
	input wire logic [31:0] wrSetup,
	output logic nvLoadValid,
	output logic [31:0] nvSetup,
	output logic [31:0] nvRamp,
	output logic [31:0] nvStartup,
	output logic [31:0] nvWatchdog
);
	// contents survive reset, as a nonvolatile part would
	initial
	begin
		nvLoadValid = 1'b0;
		{nvSetup, nvRamp, nvStartup, nvWatchdog} = {SETUP0, RAMP0, START0, WD0};
	end
	// load pulse follows the request; each write pulse stores its word
	always @(posedge ref_clk)
	begin
		nvLoadValid <= loadReq;
		case (nvWrite)
			cmd_handler_pkg::NV_SETUP: nvSetup <= wrSetup;
			cmd_handler_pkg::NV_RAMP: nvRamp <= wrData;
			cmd_handler_pkg::NV_STARTUP: nvStartup <= wrData;
			cmd_handler_pkg::NV_WATCHDOG: nvWatchdog <= wrData;
			default: ;
		endcase
	end
endmodule

//--- testbench/tb_top.sv
// bench: command sequences against the handler and its store
// assumes: short watchdog tick; replies checked from a queue of notes
`timescale 1ns/1ps
module tb_top;
	localparam logic [31:0] SU0 = 32'h3107_01C0, SU1 = 32'h3107_0182, RP0 = 32'h0000_03E8;
	localparam logic [31:0] SV0 = 32'h0000_01F4, SV1 = 32'h0000_02BC, RP1 = 32'h0000_2710;
	localparam logic [7:0] OK_E = {1'b1, cmd_handler_pkg::ERR_NONE, 3'h0};
	localparam logic [7:0] WP_E = {1'b0, cmd_handler_pkg::ERR_WRITE_PROTECTED, 3'h0};
	localparam logic [7:0] VAL_E = {1'b0, cmd_handler_pkg::ERR_VALUE, 3'h0};
	localparam logic [7:0] SYN_E = {1'b0, cmd_handler_pkg::ERR_SYNTAX, 3'h0};
	localparam logic [7:0] SUM_E = {1'b0, cmd_handler_pkg::ERR_BAD_CHECKSUM, 3'h0};
	logic ref_clk, rst_b, cmdValid, loadReq, outSetError, outSlewing, trimRangeError, sumBad;
	logic nvLoadValid, replyValid_r, outSetValid_r, trimOutValid_r, trimOutHigh_r;
	logic trimReadbackValid_r, trimReadbackHigh_r, writeEnable_r;
	cmd_handler_pkg::cmd_s cmdIn;
	cmd_handler_pkg::reply_s reply_r;
	cmd_handler_pkg::nv_e nvWrite_r;
	logic [31:0] nvSetup, nvRamp, nvStartup, nvWatchdog, nvWriteData_r, nvWriteSetup_r;
	logic [31:0] outTarget_r, outRate_r, activeSetup_r, trimOutMeasured_r, v;
	logic [3:0] hexN;
	logic [7:0] rnd;
	logic [41:0] note;
	logic [41:0] notes[$];
	int num_errors, n_checks, cycles, waited;
	setup_slew_watchdog_command_handler #(.TICK_COUNT(4)) setup_slew_watchdog_command_handler_inst (
		.ref_clk(ref_clk), .rst_b(rst_b), .cmdValid(cmdValid), .cmdIn(cmdIn),
		.nvLoadValid(nvLoadValid), .nvSetup(nvSetup), .nvRamp(nvRamp),
		.nvStartup(nvStartup), .nvWatchdog(nvWatchdog), .outSetError(outSetError),
		.outSlewing(outSlewing), .trimRangeError(trimRangeError), .reply_r(reply_r),
		.replyValid_r(replyValid_r), .nvWrite_r(nvWrite_r), .nvWriteData_r(nvWriteData_r),
		.nvWriteSetup_r(nvWriteSetup_r), .outSetValid_r(outSetValid_r),
		.outTarget_r(outTarget_r), .outRate_r(outRate_r), .outFreeze_r(),
		.controllerReset_r(), .activeSetup_r(activeSetup_r), .trimOutValid_r(trimOutValid_r),
		.trimOutHigh_r(trimOutHigh_r), .trimOutMeasured_r(trimOutMeasured_r),
		.trimReadbackValid_r(trimReadbackValid_r), .trimReadbackHigh_r(trimReadbackHigh_r),
		.writeEnable_r(writeEnable_r)
	);
	nv_store_model #(.SETUP0(SU0), .RAMP0(RP0), .START0(SV0), .WD0(cmd_handler_pkg::WD_DISABLE_VAL))
		nv_store_model_inst (.ref_clk(ref_clk), .loadReq(loadReq), .nvWrite(nvWrite_r),
		.wrData(nvWriteData_r), .wrSetup(nvWriteSetup_r), .nvLoadValid(nvLoadValid),
		.nvSetup(nvSetup), .nvRamp(nvRamp), .nvStartup(nvStartup), .nvWatchdog(nvWatchdog));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [7:0] st(input cmd_handler_pkg::nv_e n);
		return {OK_E[7:3], n};
	endfunction
	task automatic end_of_test;
		if (num_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string nm, input logic [39:0] got, input logic [39:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one command, its expected reply noted for the watcher
	task automatic send(input cmd_handler_pkg::cmd_e c, input logic [31:0] d,
		input logic [7:0] e, input logic [33:0] r);
		@(posedge ref_clk);
		rnd = lfsr(rnd);
		cmdValid <= 1'b1;
		cmdIn <= '{code: c, hashPrompt: rnd[0], checksumPresent: sumBad, checksumOk: 1'b0,
			syntaxOk: 1'b1, value: d, setup: d, hexCount: hexN};
		notes.push_back({r, e});
		@(posedge ref_clk);
		cmdValid <= 1'b0;
	endtask
	task automatic we;
		send(cmd_handler_pkg::CMD_WRITE_ENABLE, 32'h0, OK_E, 34'h0);
	endtask
	task automatic waitOut(input int n);
		int i;
		i = 0;
		do
		begin
			@(posedge ref_clk);
			#1;
			i++;
		end
		while (i < n && outSetValid_r !== 1'b1);
		waited = i;
	endtask
	task automatic power(input logic err);
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		outSetError <= err;
		loadReq <= 1'b1;
		@(posedge ref_clk);
		loadReq <= 1'b0;
		waitOut(5);
		check("bootRate", outRate_r, RP0);
		check("bootTarget", outTarget_r, SV0);
	endtask
	// free-running clock
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// watcher: oldest note against each reply
	always @(posedge ref_clk)
		if (replyValid_r === 1'b1)
		begin
			note = notes.pop_front();
			check("reply", {reply_r.ok, reply_r.err, nvWrite_r}, note[7:0]);
			if (note[40])
				check("data", note[41] ? reply_r.setup : reply_r.value, note[39:8]);
		end
	// hang guard
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			num_errors++;
			end_of_test();
		end
	end
	// main sequence
	initial
	begin
		{rst_b, cmdValid, loadReq, outSetError, outSlewing, trimRangeError, sumBad} = '0;
		cmdIn = '0;
		hexN = 4'h8;
		rnd = 8'h48;
		power(1'b0);
		power(1'b1);
		waitOut(5);
		check("bootFault", outTarget_r, cmd_handler_pkg::NEG_FULL_SCALE);
		@(posedge ref_clk);
		outSetError <= 1'b0;
		send(cmd_handler_pkg::CMD_READ_SETUP, 32'h0, OK_E, {2'b11, SU0});
		send(cmd_handler_pkg::CMD_READ_SETUP_ALIAS, 32'h0, OK_E, {2'b11, SU0});
		send(cmd_handler_pkg::CMD_READ_STARTUP_VALUE, 32'h0, OK_E, {2'b01, SV0});
		send(cmd_handler_pkg::CMD_READ_WATCHDOG_PERIOD, 32'h0, OK_E,
			{2'b01, cmd_handler_pkg::WD_DISABLE_VAL});
		rnd = lfsr(rnd);
		v = {24'h0, rnd};
		send(cmd_handler_pkg::CMD_RAMP_RATE_VOLATILE, v, OK_E, 34'h0);
		#1 check("rateV", outRate_r, v);
		send(cmd_handler_pkg::CMD_READ_STORED_RAMP, 32'h0, OK_E, {2'b01, RP0});
		send(cmd_handler_pkg::CMD_SETUP_WRITE, SU1, WP_E, 34'h0);
		we();
		hexN = 4'h7;
		send(cmd_handler_pkg::CMD_SETUP_WRITE, SU1, SYN_E, 34'h0);
		hexN = 4'h8;
		send(cmd_handler_pkg::CMD_SETUP_WRITE, SU1, st(cmd_handler_pkg::NV_SETUP), 34'h0);
		#1 check("enable", writeEnable_r, 1'b0);
		check("activeOld", activeSetup_r, SU0);
		send(cmd_handler_pkg::CMD_READ_SETUP, 32'h0, OK_E, {2'b11, SU1});
		sumBad = 1'b1;
		send(cmd_handler_pkg::CMD_READ_SETUP, 32'h0, SUM_E, 34'h0);
		sumBad = 1'b0;
		send(cmd_handler_pkg::CMD_REMOTE_RESTART, 32'h0, WP_E, 34'h0);
		we();
		send(cmd_handler_pkg::CMD_REMOTE_RESTART, 32'h0, OK_E, 34'h0);
		#1 check("active", activeSetup_r, SU1);
		send(cmd_handler_pkg::CMD_STARTUP_VALUE_PROGRAM, SV1, WP_E, 34'h0);
		we();
		send(cmd_handler_pkg::CMD_STARTUP_VALUE_PROGRAM, SV1, st(cmd_handler_pkg::NV_STARTUP), 34'h0);
		we();
		send(cmd_handler_pkg::CMD_WRITE_RAMP_PERSISTENT, RP1, st(cmd_handler_pkg::NV_RAMP), 34'h0);
		#1 check("rate", outRate_r, RP1);
		send(cmd_handler_pkg::CMD_READ_STORED_RAMP, 32'h0, OK_E, {2'b01, RP1});
		we();
		send(cmd_handler_pkg::CMD_WATCHDOG_PERIOD_PROGRAM, 32'h0F, VAL_E, 34'h0);
		send(cmd_handler_pkg::CMD_WATCHDOG_PERIOD_PROGRAM, 32'h10,
			st(cmd_handler_pkg::NV_WATCHDOG), 34'h0);
		waitOut(100);
		check("dogFire", {outSetValid_r, outTarget_r}, {1'b1, SV1});
		check("dogTime", waited, 32'h10 * 32'h4);
		we();
		send(cmd_handler_pkg::CMD_WATCHDOG_PERIOD_PROGRAM, cmd_handler_pkg::WD_DISABLE_VAL,
			st(cmd_handler_pkg::NV_WATCHDOG), 34'h0);
		waitOut(100);
		check("dogOff", outSetValid_r, 1'b0);
		we();
		outSlewing <= 1'b1;
		send(cmd_handler_pkg::CMD_TRIM_OUTPUT_LOW, 32'h0C, VAL_E, 34'h0);
		send(cmd_handler_pkg::CMD_TRIM_READBACK_HIGH, 32'h0, VAL_E, 34'h0);
		outSlewing <= 1'b0;
		trimRangeError <= 1'b1;
		send(cmd_handler_pkg::CMD_TRIM_OUTPUT_HIGH, 32'h7CE, VAL_E, 34'h0);
		trimRangeError <= 1'b0;
		send(cmd_handler_pkg::CMD_TRIM_OUTPUT_HIGH, 32'h7CE, OK_E, 34'h0);
		#1 check("trimOut", {trimOutValid_r, trimOutHigh_r, trimOutMeasured_r}, {2'b11, 32'h7CE});
		we();
		send(cmd_handler_pkg::CMD_TRIM_READBACK_LOW, 32'h0, OK_E, 34'h0);
		#1 check("trimBack", {trimReadbackValid_r, trimReadbackHigh_r}, 2'b10);
		repeat (4) @(posedge ref_clk);
		// the store must hold what the handler asked it to write
		check("nvSetup", nvSetup, SU1);
		check("nvRamp", nvRamp, RP1);
		check("nvStart", nvStartup, SV1);
		check("nvDog", nvWatchdog, cmd_handler_pkg::WD_DISABLE_VAL);
		check("pending", notes.size(), 0);
		end_of_test();
	end
endmodule
